/* hdl/eisx_defines.svh */
`ifndef EISX_DEFINES_SVH
`define EISX_DEFINES_SVH

// ------------------------------------------------------------
// register bus geometry
// ------------------------------------------------------------
`define EISX_ADDR_W 16
`define EISX_DATA_W 8

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define EISX_OFS_SENSE_UPPER 16'hFF2C
`define EISX_OFS_SENSE_LOWER 16'hFF2D
`define EISX_OFS_REQ_ENABLES 16'hFF2E
`define EISX_OFS_REQ_FLAGS 16'hFF2F
`define EISX_OFS_ACT_BASE 16'hFF30
`define EISX_OFS_SW_VECTOR 16'hFF37
`define EISX_OFS_EVT_STATUS 16'hFF38
`define EISX_OFS_EVT_MASK 16'hFF39

// ------------------------------------------------------------
// reset values and field positions
// ------------------------------------------------------------
`define EISX_RST_BYTE 8'h00
`define EISX_RST_SENSE 16'h0000
`define EISX_RST_ACT 48'h0000_0000_0000
`define EISX_RST_VEC 7'h00
`define EISX_RST_PINS 8'hFF
`define EISX_SOFTWARE_ACTIVATION_ENABLE_BIT 7
`define EISX_VEC_MSB 6
`define EISX_ACT_REGS 6
`define EISX_ACT_IDX_W 6
`define EISX_NUM_INPUTS 8

`endif

/* hdl/eisx_pkg.sv */
package eisx_pkg;

  // ------------------------------------------------------------
  // sense condition encoding, one pair per input
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    EISX_SENSE_LOW = 2'h0,
    EISX_SENSE_FALL = 2'h1,
    EISX_SENSE_RISE = 2'h2,
    EISX_SENSE_BOTH = 2'h3
  } eisx_sense_e;

  // ------------------------------------------------------------
  // state of the edge/level detector
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] prev;
  } eisx_det_s;

  // ------------------------------------------------------------
  // state of the controller
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] sense;
    logic [7:0] enables;
    logic [7:0] flags;
    logic [47:0] act_en;
    logic [6:0] sw_vector;
    logic sw_enable;
    logic sw_seen_one;
    logic [7:0] evt_status;
    logic [7:0] evt_mask;
    logic [7:0] rdata;
    logic [7:0] ext_irq;
    logic [7:0] act_req;
    logic irq;
  } eisx_ctl_s;

endpackage : eisx_pkg

/* hdl/eisx_sense_if.sv */
interface eisx_sense_if;
  logic [7:0] pins;
  logic [15:0] sense;
  logic [7:0] hit;

  modport det (
    input pins,
    input sense,
    output hit
  );

  modport ctl (
    output pins,
    output sense,
    input hit
  );
endinterface : eisx_sense_if

/* hdl/eisx_sense_detect.sv */
`include "eisx_defines.svh"

module eisx_sense_detect (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  eisx_sense_if.det sif
);

  eisx_pkg::eisx_det_s det_reg;
  eisx_pkg::eisx_det_s det_next;

  // ------------------------------------------------------------
  // sense mode decode
  // ------------------------------------------------------------
  function automatic logic sense_hit(input logic [1:0] mode, input logic now, input logic was);
    case (eisx_pkg::eisx_sense_e'(mode))
      eisx_pkg::EISX_SENSE_LOW: sense_hit = !now;
      eisx_pkg::EISX_SENSE_FALL: sense_hit = was && !now;
      eisx_pkg::EISX_SENSE_RISE: sense_hit = !was && now;
      eisx_pkg::EISX_SENSE_BOTH: sense_hit = was != now;
      default: sense_hit = 1'b0;
    endcase
  endfunction : sense_hit

  // ------------------------------------------------------------
  // synchroniser and history
  // ------------------------------------------------------------
  always_comb begin
    det_next = det_reg;
    det_next.sync1 = sif.pins;
    det_next.sync2 = det_reg.sync1;
    det_next.prev = det_reg.sync2;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // pins idle high so no false falling edge after reset
      det_reg.sync1 <= `EISX_RST_PINS;
      det_reg.sync2 <= `EISX_RST_PINS;
      det_reg.prev <= `EISX_RST_PINS;
    end else begin
      det_reg <= det_next;
    end
  end

  // ------------------------------------------------------------
  // per-input detection
  // ------------------------------------------------------------
  for (genvar n = 0; n < `EISX_NUM_INPUTS; n++) begin : g_det
    assign sif.hit[n] = sense_hit(sif.sense[2*n+1 -: 2], det_reg.sync2[n], det_reg.prev[n]); // [RQ1]
  end

endmodule : eisx_sense_detect

/* hdl/eisx_ext_irq_ctl.sv */
// Functional notes
// [RQ1] sense pair selects low, fall, rise, both
// [RQ2] upper register inputs 7-4, lower 3-0
// [RQ3] per-input enable bit, reset zero
// [RQ4] per-input flag set on sense condition
// [RQ5] flag cleared only by writing zero
// [RQ6] activation enable cleared on end conditions
// [RQ7] activation enable held while transfers remain
// [RQ8] first enable register bit7 is input0
// [RQ9] sw enable: one always, zero after read; a one written in the cycle of a software transfer end is lost
// [RQ10] request when flag and enable both set
`include "eisx_defines.svh"

module eisx_ext_irq_ctl #(
  parameter int NUM_ACT_REGS = `EISX_ACT_REGS
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] ext_req_i,
  input wire logic [`EISX_ADDR_W-1:0] addr_i,
  input wire logic [`EISX_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`EISX_DATA_W-1:0] rdata_o,
  input wire logic xfer_end_i,
  input wire logic [`EISX_ACT_IDX_W-1:0] xfer_src_i,
  input wire logic xfer_count_done_i,
  input wire logic disable_select_i,
  input wire logic sw_xfer_end_i,
  output logic [7:0] ext_irq_o,
  output logic [7:0] act_req_o,
  output logic sw_act_o,
  output logic [`EISX_VEC_MSB:0] sw_vector_o,
  output logic irq_o
);

  eisx_pkg::eisx_ctl_s ctl_reg;
  eisx_pkg::eisx_ctl_s ctl_next;

  eisx_sense_if sif ();

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic addr_is(input logic [`EISX_ADDR_W-1:0] a, input logic [`EISX_ADDR_W-1:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  function automatic logic act_reg_sel(input logic [`EISX_ADDR_W-1:0] a, input int idx);
    act_reg_sel = (a == `EISX_ADDR_W'(`EISX_OFS_ACT_BASE + idx));
  endfunction : act_reg_sel

  // ------------------------------------------------------------
  // detector
  // ------------------------------------------------------------
  assign sif.pins = ext_req_i;
  assign sif.sense = ctl_reg.sense;

  eisx_sense_detect u_detect (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .sif(sif.det)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] rd_val;
    logic [47:0] act_clr;
    logic [7:0] act_first;
    rd_val = `EISX_RST_BYTE;
    act_clr = `EISX_RST_ACT;
    act_first = `EISX_RST_BYTE;
    ctl_next = ctl_reg;

    // register writes
    if (wr_i) begin
      if (addr_is(addr_i, `EISX_OFS_SENSE_UPPER)) begin
        ctl_next.sense[15:8] = wdata_i; // [RQ2]
      end
      if (addr_is(addr_i, `EISX_OFS_SENSE_LOWER)) begin
        ctl_next.sense[7:0] = wdata_i; // [RQ2]
      end
      if (addr_is(addr_i, `EISX_OFS_REQ_ENABLES)) begin
        ctl_next.enables = wdata_i; // [RQ3]
      end
      if (addr_is(addr_i, `EISX_OFS_REQ_FLAGS)) begin
        // ones are ignored, zeros clear
        ctl_next.flags = ctl_reg.flags & wdata_i; // [RQ5]
      end
      if (addr_is(addr_i, `EISX_OFS_EVT_MASK)) begin
        ctl_next.evt_mask = wdata_i;
      end
      if (addr_is(addr_i, `EISX_OFS_SW_VECTOR)) begin
        ctl_next.sw_vector = wdata_i[`EISX_VEC_MSB:0];
        if (wdata_i[`EISX_SOFTWARE_ACTIVATION_ENABLE_BIT]) begin
          ctl_next.sw_enable = 1'b1; // [RQ9]
          // a fresh set needs a fresh read before a zero write
          ctl_next.sw_seen_one = 1'b0; // [RQ9]
        end else if (ctl_reg.sw_seen_one) begin
          ctl_next.sw_enable = 1'b0; // [RQ9]
          ctl_next.sw_seen_one = 1'b0;
        end
      end
    end

    // transfer-end clearing of activation enables
    if (xfer_end_i && (disable_select_i || xfer_count_done_i)) begin
      act_clr[xfer_src_i] = 1'b1; // [RQ6]
    end
    // without an end condition the bit simply holds
    ctl_next.act_en = ctl_reg.act_en & ~act_clr; // [RQ7]
    for (int i = 0; i < NUM_ACT_REGS; i++) begin
      // software write lands after the hardware clear of the same cycle
      if (wr_i && act_reg_sel(addr_i, i)) begin
        ctl_next.act_en[8*i +: 8] = wdata_i;
      end
    end

    // software activation ends like any other transfer
    if (sw_xfer_end_i && (disable_select_i || xfer_count_done_i)) begin
      ctl_next.sw_enable = 1'b0; // [RQ6]
      ctl_next.sw_seen_one = 1'b0;
    end

    // sense events: set wins over a same-cycle clear
    ctl_next.flags = ctl_next.flags | sif.hit; // [RQ4]

    // reads, data appear in the following cycle
    if (rd_i) begin
      if (addr_is(addr_i, `EISX_OFS_SENSE_UPPER)) begin
        rd_val = ctl_reg.sense[15:8];
      end
      if (addr_is(addr_i, `EISX_OFS_SENSE_LOWER)) begin
        rd_val = ctl_reg.sense[7:0];
      end
      if (addr_is(addr_i, `EISX_OFS_REQ_ENABLES)) begin
        rd_val = ctl_reg.enables;
      end
      if (addr_is(addr_i, `EISX_OFS_REQ_FLAGS)) begin
        rd_val = ctl_reg.flags;
      end
      if (addr_is(addr_i, `EISX_OFS_EVT_MASK)) begin
        rd_val = ctl_reg.evt_mask;
      end
      if (addr_is(addr_i, `EISX_OFS_EVT_STATUS)) begin
        rd_val = ctl_reg.evt_status;
      end
      if (addr_is(addr_i, `EISX_OFS_SW_VECTOR)) begin
        rd_val = {ctl_reg.sw_enable, ctl_reg.sw_vector};
        if (ctl_reg.sw_enable) begin
          ctl_next.sw_seen_one = 1'b1; // [RQ9]
        end
      end
      for (int i = 0; i < NUM_ACT_REGS; i++) begin
        if (act_reg_sel(addr_i, i)) begin
          rd_val = ctl_reg.act_en[8*i +: 8];
        end
      end
    end
    ctl_next.rdata = rd_val;

    // event status: read clears, new event wins
    if (rd_i && addr_is(addr_i, `EISX_OFS_EVT_STATUS)) begin
      ctl_next.evt_status = `EISX_RST_BYTE;
    end
    ctl_next.evt_status = ctl_next.evt_status | sif.hit;

    // first activation register lists input 0 at bit 7
    for (int n = 0; n < `EISX_NUM_INPUTS; n++) begin
      act_first[n] = ctl_reg.act_en[`EISX_NUM_INPUTS-1-n]; // [RQ8]
    end

    ctl_next.ext_irq = ctl_reg.flags & ctl_reg.enables; // [RQ10]
    ctl_next.act_req = ctl_reg.flags & act_first; // [RQ8]
    ctl_next.irq = |(ctl_next.evt_status & ctl_next.evt_mask);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_reg.sense <= `EISX_RST_SENSE; // [RQ2]
      ctl_reg.enables <= `EISX_RST_BYTE; // [RQ3]
      ctl_reg.flags <= `EISX_RST_BYTE; // [RQ4]
      ctl_reg.act_en <= `EISX_RST_ACT;
      ctl_reg.sw_vector <= `EISX_RST_VEC;
      ctl_reg.sw_enable <= 1'b0;
      ctl_reg.sw_seen_one <= 1'b0;
      ctl_reg.evt_status <= `EISX_RST_BYTE;
      ctl_reg.evt_mask <= `EISX_RST_BYTE;
      ctl_reg.rdata <= `EISX_RST_BYTE;
      ctl_reg.ext_irq <= `EISX_RST_BYTE;
      ctl_reg.act_req <= `EISX_RST_BYTE;
      ctl_reg.irq <= 1'b0;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rdata_o = ctl_reg.rdata;
  assign ext_irq_o = ctl_reg.ext_irq;
  assign act_req_o = ctl_reg.act_req;
  assign sw_act_o = ctl_reg.sw_enable;
  assign sw_vector_o = ctl_reg.sw_vector;
  assign irq_o = ctl_reg.irq;

endmodule : eisx_ext_irq_ctl

/* dv/eisx_props.sv */
`include "eisx_defines.svh"

module eisx_props (
  input logic sys_clk_i,
  input logic rst_i,
  input logic [15:0] addr_i,
  input logic [7:0] wdata_i,
  input logic wr_i,
  input logic rd_i,
  input logic [7:0] rdata_o,
  input logic xfer_end_i,
  input logic [5:0] xfer_src_i,
  input logic xfer_count_done_i,
  input logic disable_select_i,
  input logic sw_xfer_end_i,
  input logic [7:0] ext_irq_o,
  input logic [7:0] act_req_o,
  input logic sw_act_o,
  input logic [6:0] sw_vector_o,
  input logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] VEC = `EISX_OFS_SW_VECTOR;
  localparam logic [15:0] ACT = `EISX_OFS_ACT_BASE;
  localparam logic [15:0] ENB = `EISX_OFS_REQ_ENABLES;
  localparam logic [15:0] MSK = `EISX_OFS_EVT_MASK;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence sw_set;
    wr_i && addr_i == VEC && wdata_i[7] && !sw_xfer_end_i;
  endsequence
  sequence sw_zero;
    wr_i && addr_i == VEC && !wdata_i[7] && !sw_xfer_end_i;
  endsequence
  // a software write in the same cycle would win, so it is excluded
  sequence act_end;
    xfer_end_i && (disable_select_i || xfer_count_done_i) && xfer_src_i < 6'h08 && !(wr_i && addr_i == ACT);
  endsequence
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (rd_i && addr_i == 16'hFF36 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_sw_set_one: assert property (sw_set |=> {sw_act_o, sw_vector_o} == $past(wdata_i))
    else $error("software activation write lost");
  a_sw_zero_held: assert property (sw_set ##1 sw_zero |=> sw_act_o)
    else $error("zero write took effect without read");
  a_act_cleared: assert property (act_end ##1 !(wr_i && addr_i == ACT) |=>
    act_req_o[3'(7 - $past(xfer_src_i, 2))] == 1'b0) else $error("activation survived end");
  a_irq_enable_off: assert property (wr_i && addr_i == ENB && wdata_i == 8'h00 ##1
    !(wr_i && addr_i == ENB) |=> ext_irq_o == 8'h00) else $error("request while disabled");
  a_irq_masked_off: assert property (wr_i && addr_i == MSK && wdata_i == 8'h00 ##1
    !(wr_i && addr_i == MSK) |=> !irq_o) else $error("interrupt while masked");
  a_reset_quiet: assert property ($fell(rst_i) |-> {ext_irq_o, act_req_o, sw_act_o, irq_o} == 18'h00000)
    else $error("outputs active after reset");
endmodule : eisx_props

/* dv/eisx_xfer_model.sv */
module eisx_xfer_model #(
  parameter int LAT = 3,
  parameter int COUNT = 3
) (
  input logic sys_clk_i,
  input logic rst_i,
  input logic [7:0] act_req_i,
  output logic xfer_end_o,
  output logic [5:0] xfer_src_o,
  output logic count_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt, wt, n;
  always_comb begin
    n = 0;
    for (int i = 7; i >= 0; i--)
      if (act_req_i[i])
        n = i;
  end
  // ------------------------------------------------------------
  // transfer engine: one request per LAT+1 cycles
  // ------------------------------------------------------------
  // unqualified lines scrambled so stale values never pass for valid
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= COUNT;
      wt <= 0;
      xfer_end_o <= 1'b0;
      xfer_src_o <= 6'h15;
      count_done_o <= 1'b0;
    end else begin
      xfer_end_o <= 1'b0;
      xfer_src_o <= ~xfer_src_o;
      count_done_o <= ~count_done_o;
      if (wt > 0)
        wt <= wt - 1;
      else if (act_req_i != 8'h00) begin
        xfer_end_o <= 1'b1;
        xfer_src_o <= 6'(7 - n);
        count_done_o <= cnt == 1;
        cnt <= cnt == 1 ? COUNT : cnt - 1;
        wt <= LAT;
      end
    end
  end
endmodule : eisx_xfer_model

/* dv/eisx_ext_irq_ctl_tb.sv */
`include "eisx_defines.svh"

module eisx_ext_irq_ctl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, dis = 1'b0, swe = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, pins = 8'hFF, rdata, eirq, areq;
  logic [6:0] vec;
  logic [5:0] src;
  logic xend, cdone, swa, irq;
  int fail_count = 0, tests_run = 0, cyc = 0, ends = 0;
  initial forever #2 clk = ~clk;
  eisx_ext_irq_ctl eisx_ext_irq_ctl_i (.sys_clk_i(clk), .rst_i(rst), .ext_req_i(pins), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .xfer_end_i(xend), .xfer_src_i(src),
    .xfer_count_done_i(cdone), .disable_select_i(dis), .sw_xfer_end_i(swe), .ext_irq_o(eirq),
    .act_req_o(areq), .sw_act_o(swa), .sw_vector_o(vec), .irq_o(irq));
  eisx_xfer_model eisx_xfer_model_i (.sys_clk_i(clk), .rst_i(rst), .act_req_i(areq), .xfer_end_o(xend),
    .xfer_src_o(src), .count_done_o(cdone));
  task automatic conclude();
    $display("tests run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ends <= ends + int'(xend);
    if (cyc == 5000) begin
      fail_count++;
      conclude();
    end
  end
  // ------------------------------------------------------------
  // bus tasks: a write leaves its strobe up until the next task
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr8(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    {wr, rd} <= 2'b10;
    addr <= a;
    wdata <= v;
  endtask : wr8
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      {wr, rd} <= 2'b00;
    end
  endtask : idle
  task automatic rd8(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    {wr, rd} <= 2'b01;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    // data stand until this edge; looked at before it updates them
    @(posedge clk);
    chk(rdata, exp);
  endtask : rd8
  initial begin
    logic [7:0] b;
    int e0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int a = 16'hFF2C; a <= 16'hFF39; a++) rd8(16'(a), 8'h00);
    for (int a = 16'hFF2C; a <= 16'hFF35; a++) begin
      wr8(16'(a), 8'h5A);
      rd8(16'(a), a == 16'hFF2F ? 8'h00 : 8'h5A);
      wr8(16'(a), 8'h00);
    end
    idle(1);
    $display("test registers done");
    wr8(`EISX_OFS_EVT_MASK, 8'h02);
    for (int m = 0; m < 4; m++) begin
      b = 8'h02 << (2 * m);
      wr8(`EISX_OFS_SENSE_UPPER, m > 1 ? 8'(m << (4 * m - 6)) : 8'h00);
      wr8(`EISX_OFS_SENSE_LOWER, m < 2 ? 8'(m << (4 * m + 2)) : 8'h00);
      wr8(`EISX_OFS_REQ_ENABLES, b);
      idle(1);
      pins <= ~b;
      idle(6);
      rd8(`EISX_OFS_REQ_FLAGS, m == 2 ? 8'h00 : b);
      chk(eirq, m == 2 ? 8'h00 : b);
      wr8(`EISX_OFS_REQ_FLAGS, 8'hFF);
      rd8(`EISX_OFS_REQ_FLAGS, m == 2 ? 8'h00 : b);
      wr8(`EISX_OFS_REQ_FLAGS, 8'h00);
      rd8(`EISX_OFS_REQ_FLAGS, m == 0 ? b : 8'h00);
      pins <= 8'hFF;
      idle(6);
      rd8(`EISX_OFS_REQ_FLAGS, m == 1 ? 8'h00 : b);
      wr8(`EISX_OFS_REQ_FLAGS, 8'h00);
    end
    wr8(`EISX_OFS_REQ_ENABLES, 8'h00);
    idle(2);
    chk({7'h00, irq}, 8'h01);
    rd8(`EISX_OFS_EVT_STATUS, 8'hAA);
    chk({7'h00, irq}, 8'h00);
    wr8(`EISX_OFS_EVT_MASK, 8'h00);
    idle(2);
    $display("test sensing done");
    wr8(`EISX_OFS_SENSE_UPPER, 8'h00);
    wr8(`EISX_OFS_SENSE_LOWER, 8'h01);
    for (int k = 0; k < 2; k++) begin
      dis <= k[0];
      e0 = ends;
      wr8(`EISX_OFS_ACT_BASE, 8'h80);
      idle(1);
      pins <= 8'hFE;
      idle(40);
      rd8(`EISX_OFS_ACT_BASE, 8'h00);
      chk(8'(ends - e0), k == 1 ? 8'h01 : 8'h03);
      pins <= 8'hFF;
      wr8(`EISX_OFS_REQ_FLAGS, 8'h00);
    end
    idle(1);
    $display("test activation done");
    wr8(`EISX_OFS_SW_VECTOR, 8'h81);
    wr8(`EISX_OFS_SW_VECTOR, 8'h05);
    rd8(`EISX_OFS_SW_VECTOR, 8'h85);
    wr8(`EISX_OFS_SW_VECTOR, 8'h05);
    rd8(`EISX_OFS_SW_VECTOR, 8'h05);
    wr8(`EISX_OFS_SW_VECTOR, 8'h81);
    idle(2);
    chk({swa, vec}, 8'h81);
    swe <= 1'b1;
    idle(1);
    swe <= 1'b0;
    idle(1);
    chk({swa, vec}, 8'h01);
    $display("test software activation done");
    conclude();
  end
endmodule : eisx_ext_irq_ctl_tb

bind eisx_ext_irq_ctl eisx_props eisx_props_i (.*);
